// >>> shared/gpx_defs.svh
// Register indices, field positions, reset values and bus answers of the port slice
`ifndef GPX_DEFS_SVH
`define GPX_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define GPX_IDX_DATA 6'h00
`define GPX_IDX_DIR 6'h01
`define GPX_IDX_OPT 6'h02
`define GPX_IDX_SENS 6'h03

// ----------------------------------------------------------------------------
// Sensitivity register fields
// ----------------------------------------------------------------------------
`define GPX_SENS_G0_LSB 0
`define GPX_SENS_G1_LSB 2
`define GPX_SENS_W 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GPX_RST_REG 8'h00
`define GPX_RST_SENS 4'h0
`define GPX_RST_LVL 1'b1

// ----------------------------------------------------------------------------
// AXI4-Lite answers
// ----------------------------------------------------------------------------
`define GPX_RESP_OKAY 2'h0
`define GPX_RESP_SLVERR 2'h2

`endif

// >>> shared/gpx_pkg.sv
// Types shared by the port slice modules
package gpx_pkg;

    // ------------------------------------------------------------------------
    // Interrupt sensitivity encodings
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        GPX_SENS_FALL_LOW = 2'h0,
        GPX_SENS_RISE = 2'h1,
        GPX_SENS_FALL = 2'h2,
        GPX_SENS_BOTH = 2'h3
    } gpx_sens_t;

endpackage : gpx_pkg

// >>> core/gpx_irq_group.sv
// External interrupt group: combined pin level, sensitivity check and request latch
`timescale 1ns/1ps
`default_nettype none
`include "gpx_defs.svh"

module gpx_irq_group
    import gpx_pkg::*;
#(
    parameter int NPIN = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NPIN-1:0] pin_lvl,
    input wire logic [NPIN-1:0] src_en,
    input wire gpx_sens_t sens,
    input wire logic clr,
    output logic pending
);

    logic lvl_prev;
    logic next_lvl_prev;
    logic next_pending;
    logic lvl;
    logic any_src;
    logic hit;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        // Any enabled pin held low pulls the group low and masks the others
        lvl = &(pin_lvl | ~src_en);
        any_src = |src_en;
        unique case (sens)
            GPX_SENS_FALL_LOW: hit = ~lvl;
            GPX_SENS_RISE: hit = lvl & ~lvl_prev;
            GPX_SENS_FALL: hit = ~lvl & lvl_prev;
            GPX_SENS_BOTH: hit = lvl ^ lvl_prev;
        endcase
        next_lvl_prev = lvl;
        // A new event wins over a clear in the same cycle
        next_pending = (any_src & hit) | (pending & ~clr);
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_prev <= `GPX_RST_LVL;
            pending <= 1'b0;
        end else begin
            lvl_prev <= next_lvl_prev;
            pending <= next_pending;
        end
    end

endmodule : gpx_irq_group
`default_nettype wire

// >>> core/gpx_port.sv
// Eight-pin port slice with AXI4-Lite registers, alternate functions and external interrupts
`timescale 1ns/1ps
`default_nettype none
`include "gpx_defs.svh"

module gpx_port
    import gpx_pkg::*;
#(
    parameter int NPIN = 8,
    parameter int AW = 8,
    parameter logic [NPIN-1:0] GRP0_MASK = 8'h0F,
    parameter logic [NPIN-1:0] GRP1_MASK = 8'hF0,
    parameter logic [NPIN-1:0] IRQ_CAP = 8'hFF,
    parameter logic [NPIN-1:0] PULLUP_CAP = 8'hFF,
    parameter logic [NPIN-1:0] TOD_MASK = 8'h00
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NPIN-1:0] pin_in,
    output logic [NPIN-1:0] pin_out,
    output logic [NPIN-1:0] pin_oe,
    output logic [NPIN-1:0] pin_pullup_en,
    input wire logic [NPIN-1:0] alt_en,
    input wire logic [NPIN-1:0] alt_out_en,
    input wire logic [NPIN-1:0] alt_out,
    input wire logic [NPIN-1:0] alt_od,
    output logic [NPIN-1:0] alt_in,
    input wire logic cpu_imask,
    input wire logic [1:0] vec_fetch,
    output logic [1:0] irq_req,
    output logic wake_req
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [NPIN-1:0] port_data_latch;
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] opt;
    logic [2*`GPX_SENS_W-1:0] sens;
    logic [NPIN-1:0] next_port_data_latch;
    logic [NPIN-1:0] next_dir;
    logic [NPIN-1:0] next_opt;
    logic [2*`GPX_SENS_W-1:0] next_sens;
    logic sens_wr;

    logic aw_held;
    logic w_held;
    logic [AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [AW-1:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic do_write;

    logic [NPIN-1:0] read_val;
    logic [NPIN-1:0] next_pin_out;
    logic [NPIN-1:0] next_pin_oe;
    logic [NPIN-1:0] next_pullup;
    logic [NPIN-1:0] next_alt_in;
    logic [NPIN-1:0] irq_src;
    logic [1:0] pending;
    logic [1:0] next_irq_req;
    logic next_wake;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function automatic logic addr_hit(input logic [AW-1:0] addr, input logic [5:0] idx);
        addr_hit = (addr[AW-1:2] == (AW-2)'(idx)) && (addr[1:0] == 2'h0);
    endfunction : addr_hit

    function automatic logic addr_mapped(input logic [AW-1:0] addr);
        addr_mapped = addr_hit(addr, `GPX_IDX_DATA) || addr_hit(addr, `GPX_IDX_DIR)
            || addr_hit(addr, `GPX_IDX_OPT) || addr_hit(addr, `GPX_IDX_SENS);
    endfunction : addr_mapped

    // ------------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------------
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = aw_held && w_held && !s_axi_bvalid;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_mapped(aw_addr) ? `GPX_RESP_OKAY : `GPX_RESP_SLVERR;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;

        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = `GPX_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (addr_hit(s_axi_araddr, `GPX_IDX_DATA)) begin
                next_rdata[NPIN-1:0] = read_val;
            end else if (addr_hit(s_axi_araddr, `GPX_IDX_DIR)) begin
                next_rdata[NPIN-1:0] = dir;
            end else if (addr_hit(s_axi_araddr, `GPX_IDX_OPT)) begin
                next_rdata[NPIN-1:0] = opt;
            end else if (addr_hit(s_axi_araddr, `GPX_IDX_SENS)) begin
                next_rdata[2*`GPX_SENS_W-1:0] = sens;
            end else begin
                next_rresp = `GPX_RESP_SLVERR;
            end
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GPX_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `GPX_RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ------------------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------------------
    always_comb begin
        next_port_data_latch = port_data_latch;
        next_dir = dir;
        next_opt = opt;
        next_sens = sens;
        sens_wr = 1'b0;
        if (do_write && w_strb[0]) begin
            // Data writes always land in the latch, whatever the direction
            if (addr_hit(aw_addr, `GPX_IDX_DATA)) begin
                next_port_data_latch = w_data[NPIN-1:0];
            end
            if (addr_hit(aw_addr, `GPX_IDX_DIR)) begin
                next_dir = w_data[NPIN-1:0];
            end
            if (addr_hit(aw_addr, `GPX_IDX_OPT)) begin
                next_opt = w_data[NPIN-1:0] & ~TOD_MASK;
            end
            if (addr_hit(aw_addr, `GPX_IDX_SENS)) begin
                next_sens = w_data[2*`GPX_SENS_W-1:0];
                sens_wr = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_data_latch <= `GPX_RST_REG;
            dir <= `GPX_RST_REG;
            opt <= `GPX_RST_REG;
            sens <= `GPX_RST_SENS;
        end else begin
            port_data_latch <= next_port_data_latch;
            dir <= next_dir;
            opt <= next_opt;
            sens <= next_sens;
        end
    end

    // ------------------------------------------------------------------------
    // Pin drive, pull-up, read-back and peripheral input
    // ------------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (alt_out_en[i]) begin
                // Peripheral output forces output mode and picks its drive
                next_pin_out[i] = alt_out[i];
                next_pin_oe[i] = !alt_out[i] || !(alt_od[i] || TOD_MASK[i]);
                next_pullup[i] = 1'b0;
            end else if (dir[i]) begin
                // 0 always drives low; 1 drives only in push-pull
                next_pin_out[i] = port_data_latch[i];
                next_pin_oe[i] = !port_data_latch[i] || (opt[i] && !TOD_MASK[i]);
                next_pullup[i] = 1'b0;
            end else begin
                next_pin_out[i] = 1'b0;
                next_pin_oe[i] = 1'b0;
                next_pullup[i] = opt[i] && PULLUP_CAP[i] && !TOD_MASK[i];
            end
            if (dir[i]) begin
                read_val[i] = port_data_latch[i];
            end else if (alt_en[i] && alt_out_en[i]) begin
                read_val[i] = alt_out[i];
            end else begin
                read_val[i] = pin_in[i];
            end
            next_alt_in[i] = (dir[i] && !alt_out_en[i]) ? port_data_latch[i] : pin_in[i];
            irq_src[i] = IRQ_CAP[i] && !TOD_MASK[i] && !dir[i] && opt[i];
        end
    end

    // ------------------------------------------------------------------------
    // External interrupt groups
    // ------------------------------------------------------------------------
    gpx_irq_group #(
        .NPIN(NPIN)
    ) u_grp0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_lvl(pin_in),
        .src_en(irq_src & GRP0_MASK),
        .sens(gpx_sens_t'(sens[`GPX_SENS_G0_LSB +: `GPX_SENS_W])),
        .clr(vec_fetch[0] || sens_wr),
        .pending(pending[0])
    );

    gpx_irq_group #(
        .NPIN(NPIN)
    ) u_grp1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_lvl(pin_in),
        .src_en(irq_src & GRP1_MASK),
        .sens(gpx_sens_t'(sens[`GPX_SENS_G1_LSB +: `GPX_SENS_W])),
        .clr(vec_fetch[1] || sens_wr),
        .pending(pending[1])
    );

    always_comb begin
        next_irq_req = pending & {2{!cpu_imask}};
        next_wake = |next_irq_req;
    end

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= `GPX_RST_REG;
            pin_oe <= `GPX_RST_REG;
            pin_pullup_en <= `GPX_RST_REG;
            alt_in <= `GPX_RST_REG;
            irq_req <= 2'h0;
            wake_req <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            pin_pullup_en <= next_pullup;
            alt_in <= next_alt_in;
            irq_req <= next_irq_req;
            wake_req <= next_wake;
        end
    end

endmodule : gpx_port
`default_nettype wire

// >>> verif/gpx_pin_model.sv
// Pads and board around the port slice: resolves the level seen on each pin
`timescale 1ns/1ps
`default_nettype none
module gpx_pin_model (
    input wire logic aclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup_en,
    input wire logic [7:0] ext_drv,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    // ------
    // Pin level
    // ------
    logic [7:0] wander = 8'h00;
    // An undriven pin without pull-up holds no level, so it wanders every cycle
    always @(posedge aclk) wander <= ~wander;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_drv[i];
            else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = wander[i];
        end
    end
endmodule : gpx_pin_model
`default_nettype wire

// >>> verif/gpx_port_asserts.sv
// Checker for bus handshakes, peripheral drive and request gating of the port slice
`timescale 1ns/1ps
`default_nettype none
module gpx_port_asserts #(
    parameter logic [7:0] TOD_MASK = 8'h00
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] alt_en,
    input wire logic [7:0] alt_out_en,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_od,
    input wire logic cpu_imask,
    input wire logic [1:0] irq_req,
    input wire logic wake_req
);
    // ------
    // Checks
    // ------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] drv_q, out_q, od_q;
    always_ff @(posedge aclk) begin
        drv_q <= aresetn ? (alt_en & alt_out_en) : 8'h00;
        out_q <= alt_out;
        od_q <= alt_od;
    end
    a_write_answer: assert property (
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
        else $error("write answer not on time");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not on time");
    a_read_hold: assert property (
        s_axi_rvalid |=> ($past(s_axi_rready) ? !s_axi_rvalid
            : (s_axi_rvalid && $stable(s_axi_rdata))))
        else $error("read data not held");
    a_bresp_hold: assert property (
        s_axi_bvalid |=> ($past(s_axi_bready) ? !s_axi_bvalid
            : (s_axi_bvalid && $stable(s_axi_bresp))))
        else $error("write answer not held");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_alt_value: assert property (((pin_out ^ out_q) & drv_q) == 8'h00)
        else $error("peripheral value not on pin");
    a_alt_drive: assert property (
        ((pin_oe ^ (~out_q | ~(od_q | TOD_MASK))) & drv_q) == 8'h00)
        else $error("peripheral drive kind wrong");
    a_mask_gates: assert property (cpu_imask |=> irq_req == 2'h0)
        else $error("request passed the mask");
    a_wake_follows: assert property (irq_req != 2'h0 |-> ##[0:1] wake_req)
        else $error("no wake on request");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_irq: cover property (irq_req != 2'h0);
    c_alt: cover property (drv_q != 8'h00);
endmodule : gpx_port_asserts
bind gpx_port gpx_port_asserts #(.TOD_MASK(TOD_MASK)) u_gpx_port_asserts (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .pin_out, .pin_oe, .alt_en, .alt_out_en, .alt_out,
    .alt_od, .cpu_imask, .irq_req, .wake_req);
`default_nettype wire

// >>> verif/gpx_port_bench.sv
// Self-checking bench for the port slice
`timescale 1ns/1ps
`default_nettype none
module gpx_port_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, vec_fetch, irq_req;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup_en, alt_in;
    logic [7:0] alt_en, alt_out_en, alt_out, alt_od, ext_drv, ext_en;
    logic cpu_imask, wake_req;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    gpx_port #(.TOD_MASK(8'h80)) u_gpx_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
        .pin_out, .pin_oe, .pin_pullup_en, .alt_en, .alt_out_en, .alt_out, .alt_od,
        .alt_in, .cpu_imask, .vec_fetch, .irq_req, .wake_req);
    gpx_pin_model u_gpx_pin_model (.aclk, .pin_out, .pin_oe, .pin_pullup_en, .ext_drv,
        .ext_en, .pin_in);

    // ------
    // Clock, timeout and shared tasks
    // ------
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        chk(s_axi_rdata, {24'h000000, ed});
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // ------
    // Scenarios
    // ------
    task automatic t_reset;
        chk(pin_oe, 8'h00);
        rd(8'h04, 8'h00, 2'h0);
        rd(8'h08, 8'h00, 2'h0);
        rd(8'h0C, 8'h00, 2'h0);
        rd(8'h10, 8'h00, 2'h2);
        wr(8'h14, 8'hFF, 2'h2);
        s_axi_wstrb <= 4'h0;
        wr(8'h04, 8'hFF, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd(8'h04, 8'h00, 2'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_output;
        wr(8'h00, 8'hA5, 2'h0);
        wr(8'h08, 8'h0F, 2'h0);
        wr(8'h04, 8'hFF, 2'h0);
        chk(pin_oe, 8'h5F);
        chk(pin_out & pin_oe, 8'h05);
        rd(8'h00, 8'hA5, 2'h0);
        wr(8'h08, 8'hFF, 2'h0);
        chk(pin_oe, 8'h7F);
        rd(8'h08, 8'h7F, 2'h0);
        wr(8'h00, 8'h00, 2'h0);
        chk({pin_oe, pin_out}, 16'hFF00);
        $display("test output done");
    endtask : t_output
    task automatic t_input;
        wr(8'h04, 8'h00, 2'h0);
        ext_drv <= 8'h3C;
        wr(8'h00, 8'hC3, 2'h0);
        chk(pin_oe, 8'h00);
        rd(8'h00, 8'h3C, 2'h0);
        ext_en <= 8'h00;
        cyc(2);
        chk(pin_pullup_en, 8'h7F);
        wr(8'h08, 8'h00, 2'h0);
        chk(pin_pullup_en, 8'h00);
        ext_en <= 8'hFF;
        $display("test input done");
    endtask : t_input
    task automatic t_alt;
        alt_en <= 8'h01;
        alt_out_en <= 8'h01;
        alt_out <= 8'h01;
        alt_od <= 8'h01;
        cyc(2);
        chk(pin_oe, 8'h00);
        rd(8'h00, 8'h3D, 2'h0);
        alt_out <= 8'h00;
        cyc(2);
        chk({pin_oe[0], pin_out[0]}, 2'b10);
        alt_od <= 8'h00;
        alt_out <= 8'h01;
        cyc(2);
        chk({pin_oe[0], pin_out[0]}, 2'b11);
        alt_en <= 8'h02;
        alt_out_en <= 8'h00;
        wr(8'h04, 8'hFF, 2'h0);
        chk(alt_in[1], 1'b1);
        wr(8'h04, 8'h00, 2'h0);
        chk(alt_in[1], 1'b0);
        alt_en <= 8'h00;
        $display("test alt done");
    endtask : t_alt
    task automatic t_irq;
        cpu_imask <= 1'b0;
        ext_drv <= 8'hFF;
        wr(8'h0C, 8'h02, 2'h0);
        wr(8'h08, 8'h01, 2'h0);
        ext_drv <= 8'hFE;
        cyc(3);
        chk({irq_req, wake_req}, 3'b011);
        vec_fetch <= 2'h1;
        cyc(1);
        vec_fetch <= 2'h0;
        cyc(2);
        chk(irq_req, 2'h0);
        ext_drv <= 8'hFF;
        wr(8'h08, 8'h03, 2'h0);
        ext_drv <= 8'hFD;
        cyc(3);
        chk(irq_req, 2'h1);
        wr(8'h0C, 8'h02, 2'h0);
        chk(irq_req, 2'h0);
        ext_drv <= 8'hFC;
        cyc(2);
        ext_drv <= 8'hFD;
        cyc(2);
        ext_drv <= 8'hFC;
        cyc(3);
        chk(irq_req, 2'h0);
        cpu_imask <= 1'b1;
        ext_drv <= 8'hFF;
        cyc(2);
        ext_drv <= 8'hFE;
        cyc(3);
        chk(irq_req, 2'h0);
        cpu_imask <= 1'b0;
        cyc(2);
        chk(irq_req, 2'h1);
        $display("test irq done");
    endtask : t_irq
    task automatic t_sens;
        logic [3:0] rise_tab = 4'b1011;
        logic [3:0] fall_tab = 4'b1101;
        wr(8'h08, 8'h10, 2'h0);
        for (int c = 0; c < 4; c++) begin
            ext_drv <= 8'hEF;
            cyc(2);
            wr(8'h0C, 8'(c * 4), 2'h0);
            ext_drv <= 8'hFF;
            cyc(3);
            chk(irq_req[1], rise_tab[c]);
            wr(8'h0C, 8'(c * 4), 2'h0);
            ext_drv <= 8'hEF;
            cyc(3);
            chk(irq_req[1], fall_tab[c]);
        end
        vec_fetch <= 2'h2;
        cyc(1);
        vec_fetch <= 2'h0;
        cyc(2);
        chk(irq_req, 2'h0);
        $display("test sens done");
    endtask : t_sens

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {alt_en, alt_out_en, alt_out, alt_od} = 32'h0;
        {ext_drv, ext_en} = 16'hFFFF;
        cpu_imask = 1'b0;
        vec_fetch = 2'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_output();
        t_input();
        t_alt();
        t_irq();
        t_sens();
        tally_and_finish();
    end
endmodule : gpx_port_bench
`default_nettype wire
